// ===== design/uart_mcr_defines.svh
// Purpose: Offsets, field positions, reset values and widths of the modem control block.
// Assumes: One aligned 32-bit word per register on APB.
// Notes:   Included by the control module and the checker.
//
// How it works
// - Top three control bits are read-only.
// - Loopback feeds transmit into receive, pin high.
// - Loopback ignores the external receive pin.
// - Loopback feeds modem inputs from modem outputs.
// - Looped characters never leave the device.
// - Loopback interrupt gate comes from configuration bit.
// - Loopback bit resets to zero, reads back.
// - Aux output two gates the port interrupt outside loopback.
// - Aux output one drives its pin and loops back to ring indicator.
// - RTS pin is the inverted control bit.
// - DTR pin is the inverted control bit.
`ifndef UART_MCR_DEFINES_SVH
`define UART_MCR_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define MCR_OFF_MODEM_CTRL   12'h000
`define MCR_OFF_PORT_CONFIG  12'h004
`define MCR_OFF_IRQ_ENABLE   12'h008
`define MCR_OFF_MODEM_STATE  12'h00C
`define MCR_ADDR_W           12

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define MCR_BIT_DTR          0
`define MCR_BIT_RTS          1
`define MCR_BIT_AUX1         2
`define MCR_BIT_AUX2         3
`define MCR_BIT_LOOP         4
`define MCR_RSVD_LSB         5
`define MCR_RSVD_MSB         7
`define CFG_BIT_WRAP_GATE    0

// ----------------------------------------------------------------
// Reset and fixed values
// ----------------------------------------------------------------
`define MCR_CTRL_RESET       5'h00
`define MCR_RSVD_READ        3'h7
`define CFG_RESET            1'h0
`define IRQ_EN_RESET         8'h00

`endif

// ===== design/uart_mcr_pkg.sv
// Purpose: Types shared by the modem control block.
// Assumes: The defines header is available on the include path.
// Notes:   Constants live in the header, types live here.
package uart_mcr_pkg;

	// ----------------------------------------------------------------
	// Modem input group, active-low levels as seen on the pins
	// ----------------------------------------------------------------
	typedef struct packed {
		logic dcdN;
		logic riN;
		logic dsrN;
		logic ctsN;
	} modem_lines_t;

	// ----------------------------------------------------------------
	// Writable control bits of modem_output_control
	// ----------------------------------------------------------------
	typedef struct packed {
		logic loopBack;
		logic auxOutputTwo;
		logic auxOutputOne;
		logic rts;
		logic dtr;
	} modem_ctrl_t;

	typedef enum logic [2:0] {
		BUS_IDLE   = 3'b001,
		BUS_ACCESS = 3'b010,
		BUS_DONE   = 3'b100
	} bus_state_t;

endpackage : uart_mcr_pkg

// ===== design/modem_loop_select.sv
// Purpose: Registered choice between pin inputs and the internal loop paths.
// Assumes: Pin inputs are synchronous to core_clk.
// Notes:   All outputs are flip-flops, so the loop switch settles in one cycle.
`timescale 1ns/1ps
module modem_loop_select
	import uart_mcr_pkg::*;
(
	// Clock and reset
	input  wire logic         core_clk,
	input  wire logic         rst_b,
	// Mode
	input  wire logic         loopOn,
	// Serial paths
	input  wire logic         serialTxData,
	input  wire logic         rxPin,
	// Modem paths
	input  modem_lines_t      modemPins,
	input  modem_lines_t      modemLoop,
	// Results
	output logic              rxToReceiver,
	output modem_lines_t      modemToStatus
);

	// ----------------------------------------------------------------
	// Receive data path
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rxToReceiver <= 1'b1;
		end else if (loopOn) begin
			rxToReceiver <= serialTxData;
		end else begin
			rxToReceiver <= rxPin;
		end
	end

	// ----------------------------------------------------------------
	// Modem input path
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			modemToStatus <= '1;
		end else if (loopOn) begin
			modemToStatus <= modemLoop;
		end else begin
			modemToStatus <= modemPins;
		end
	end

endmodule : modem_loop_select

// ===== design/uart_modem_control_loopback.sv
// Purpose: Modem output control register, loopback test mode and interrupt gate.
// Assumes: APB master per the protocol; all inputs synchronous to core_clk.
// Notes:   The reserved control bits read as ones; see the defines header.
`timescale 1ns/1ps
`include "uart_mcr_defines.svh"
module uart_modem_control_loopback
	import uart_mcr_pkg::*;
#(
	parameter int NUM_IRQ_SRC = 4
)
(
	// Clock and reset
	input  wire logic                    core_clk,
	input  wire logic                    rst_b,
	// APB slave
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [`MCR_ADDR_W-1:0]  paddr,
	input  wire logic [31:0]             pwdata,
	input  wire logic [3:0]              pstrb,
	output logic                         pready,
	output logic [31:0]                  prdata,
	output logic                         pslverr,
	// Serial data, internal side
	input  wire logic                    serialTxData,
	output logic                         rxToReceiver,
	// Serial data, pin side
	input  wire logic                    rxPin,
	output logic                         serialTxPin,
	// Modem pins, active low
	output logic                         rtsPinN,
	output logic                         dtrPinN,
	output logic                         auxOnePinN,
	output logic                         auxTwoPinN,
	input  modem_lines_t                 modemPins,
	// Modem inputs toward the status logic
	output modem_lines_t                 modemToStatus,
	// Interrupt
	input  wire logic [NUM_IRQ_SRC-1:0]  irqSources,
	output logic                         portIrq
);

	// ----------------------------------------------------------------
	// Parameter check
	// ----------------------------------------------------------------
	// The enable register is one byte wide, so more sources cannot be gated.
	if (NUM_IRQ_SRC < 1 || NUM_IRQ_SRC > 8) begin : gen_bad_param
		$error("NUM_IRQ_SRC must lie between 1 and 8");
	end

	// The fields must fit the low byte lane, the only lane that is decoded.
	if (`MCR_RSVD_MSB > 7 || `MCR_BIT_LOOP > 7) begin : gen_bad_field
		$error("Control fields must lie within the low byte");
	end

	// Reserved bits start right above the loop bit and span exactly three bits.
	if (`MCR_RSVD_LSB != `MCR_BIT_LOOP + 1) begin : gen_bad_rsvd_lsb
		$error("Reserved field must start above the loop bit");
	end

	if (`MCR_RSVD_MSB - `MCR_RSVD_LSB != 2) begin : gen_bad_rsvd_width
		$error("Reserved field must be three bits wide");
	end

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	function automatic logic [3:0] decodeSel(input logic [`MCR_ADDR_W-1:0] addr);
		logic [3:0] sel;
		sel = 4'h0;
		case (addr)
			`MCR_OFF_MODEM_CTRL:  sel = 4'h1;
			`MCR_OFF_PORT_CONFIG: sel = 4'h2;
			`MCR_OFF_IRQ_ENABLE:  sel = 4'h4;
			`MCR_OFF_MODEM_STATE: sel = 4'h8;
			default:              sel = 4'h0;
		endcase
		return sel;
	endfunction : decodeSel

	// ----------------------------------------------------------------
	// Bus sequencing
	// ----------------------------------------------------------------
	bus_state_t                busState_reg;
	bus_state_t                busState_next;
	logic [3:0]                addrSel;
	logic                      setupPhase;
	logic                      writeStrobe;

	assign addrSel     = decodeSel(paddr);
	assign setupPhase  = psel && !penable;
	// Writes land only in the access cycle that the sequencer is tracking.
	assign writeStrobe = psel && penable && pready && pwrite && pstrb[0] &&
		(busState_reg == BUS_ACCESS);

	always_comb begin
		busState_next = busState_reg;
		case (busState_reg)
			BUS_IDLE: begin
				if (setupPhase) begin
					busState_next = BUS_ACCESS;
				end
			end
			BUS_ACCESS: begin
				busState_next = BUS_DONE;
			end
			BUS_DONE: begin
				if (setupPhase) begin
					busState_next = BUS_ACCESS;
				end else begin
					busState_next = BUS_IDLE;
				end
			end
			default: begin
				busState_next = BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			busState_reg <= BUS_IDLE;
		end else begin
			busState_reg <= busState_next;
		end
	end

	// Ready is raised for the first access cycle only, giving zero wait states.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			pready <= 1'b0;
		end else begin
			pready <= setupPhase;
		end
	end

	// An unmapped address answers with an error and leaves every register alone.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			pslverr <= 1'b0;
		end else if (setupPhase) begin
			pslverr <= (addrSel == 4'h0);
		end else begin
			pslverr <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------------
	// Bits above the loop bit are not stored, so writes to them vanish.
	function automatic modem_ctrl_t ctrlFromWord(input logic [31:0] word);
		modem_ctrl_t c;
		c.loopBack     = word[`MCR_BIT_LOOP];
		c.auxOutputTwo = word[`MCR_BIT_AUX2];
		c.auxOutputOne = word[`MCR_BIT_AUX1];
		c.rts          = word[`MCR_BIT_RTS];
		c.dtr          = word[`MCR_BIT_DTR];
		return c;
	endfunction : ctrlFromWord

	modem_ctrl_t               ctrl_reg;
	logic                      wrapIrqGate_reg;
	logic [7:0]                irqEnable_reg;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_reg <= `MCR_CTRL_RESET;
		end else if (writeStrobe && addrSel[0]) begin
			ctrl_reg <= ctrlFromWord(pwdata);
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			wrapIrqGate_reg <= `CFG_RESET;
		end else if (writeStrobe && addrSel[1]) begin
			wrapIrqGate_reg <= pwdata[`CFG_BIT_WRAP_GATE];
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			irqEnable_reg <= `IRQ_EN_RESET;
		end else if (writeStrobe && addrSel[2]) begin
			irqEnable_reg <= pwdata[7:0];
		end
	end

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	logic [7:0]                ctrlReadback;
	logic [7:0]                stateReadback;

	always_comb begin
		ctrlReadback = 8'h00;
		ctrlReadback[`MCR_RSVD_MSB:`MCR_RSVD_LSB] = `MCR_RSVD_READ;
		ctrlReadback[`MCR_BIT_LOOP] = ctrl_reg.loopBack;
		ctrlReadback[`MCR_BIT_AUX2] = ctrl_reg.auxOutputTwo;
		ctrlReadback[`MCR_BIT_AUX1] = ctrl_reg.auxOutputOne;
		ctrlReadback[`MCR_BIT_RTS]  = ctrl_reg.rts;
		ctrlReadback[`MCR_BIT_DTR]  = ctrl_reg.dtr;
	end

	// Modem state shows asserted lines as ones, plus the transmit pin and the port interrupt.
	always_comb begin
		stateReadback    = 8'h00;
		stateReadback[0] = ~modemToStatus.ctsN;
		stateReadback[1] = ~modemToStatus.dsrN;
		stateReadback[2] = ~modemToStatus.riN;
		stateReadback[3] = ~modemToStatus.dcdN;
		stateReadback[4] = serialTxPin;
		stateReadback[5] = portIrq;
	end

	// Read data is taken at setup so that it stands through the access cycle.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			prdata <= 32'h0000_0000;
		end else if (setupPhase && !pwrite) begin
			case (addrSel)
				4'h1:    prdata <= {24'h00_0000, ctrlReadback};
				4'h2:    prdata <= {31'h0000_0000, wrapIrqGate_reg};
				4'h4:    prdata <= {24'h00_0000, irqEnable_reg};
				4'h8:    prdata <= {24'h00_0000, stateReadback};
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Modem output pins
	// ----------------------------------------------------------------
	// The pins are active low: a set control bit pulls its pin down.
	// Pins keep following the control bits in loopback, so the far end sees them.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rtsPinN <= 1'b1;
		end else begin
			rtsPinN <= ~ctrl_reg.rts;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			dtrPinN <= 1'b1;
		end else begin
			dtrPinN <= ~ctrl_reg.dtr;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			auxOnePinN <= 1'b1;
		end else begin
			auxOnePinN <= ~ctrl_reg.auxOutputOne;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			auxTwoPinN <= 1'b1;
		end else begin
			auxTwoPinN <= ~ctrl_reg.auxOutputTwo;
		end
	end

	// ----------------------------------------------------------------
	// Serial transmit pin
	// ----------------------------------------------------------------
	// The pin idles at mark during loopback so the far end sees no traffic.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			serialTxPin <= 1'b1;
		end else if (ctrl_reg.loopBack) begin
			serialTxPin <= 1'b1;
		end else begin
			serialTxPin <= serialTxData;
		end
	end

	// ----------------------------------------------------------------
	// Loop paths
	// ----------------------------------------------------------------
	modem_lines_t              modemLoop;

	// Loop levels are taken from the control bits, not the pin flops, so that
	// loopback and pin outputs change on the same edge.
	always_comb begin
		modemLoop.dsrN = ~ctrl_reg.dtr;
		modemLoop.ctsN = ~ctrl_reg.rts;
		modemLoop.riN  = ~ctrl_reg.auxOutputOne;
		modemLoop.dcdN = ~ctrl_reg.auxOutputTwo;
	end

	modem_loop_select u_loop_select (
		.core_clk      (core_clk),
		.rst_b         (rst_b),
		.loopOn        (ctrl_reg.loopBack),
		.serialTxData  (serialTxData),
		.rxPin         (rxPin),
		.modemPins     (modemPins),
		.modemLoop     (modemLoop),
		.rxToReceiver  (rxToReceiver),
		.modemToStatus (modemToStatus)
	);

	// ----------------------------------------------------------------
	// Interrupt gate
	// ----------------------------------------------------------------
	logic                      irqGate;
	logic                      irqAny;
	logic [NUM_IRQ_SRC-1:0]    irqMasked;

	always_comb begin
		if (ctrl_reg.loopBack) begin
			irqGate = wrapIrqGate_reg;
		end else begin
			irqGate = ctrl_reg.auxOutputTwo;
		end
	end

	// One gate per source, so each request is masked by its own enable bit.
	for (genvar i = 0; i < NUM_IRQ_SRC; i++) begin : gen_irq_mask
		assign irqMasked[i] = irqSources[i] && irqEnable_reg[i];
	end

	assign irqAny = |irqMasked;

	// Masking before the gate lets a mode change act on the very next edge.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			portIrq <= 1'b0;
		end else begin
			portIrq <= irqAny && irqGate;
		end
	end

endmodule : uart_modem_control_loopback

// ===== tb/uart_mcr_checker.sv
// Purpose: Port assertions for the modem control block.
// Assumes: Bound to the top module; shadow registers mirror host writes.
// Notes:   Shadows are simpler than the hidden state, so a slip shows as a mismatch.
`timescale 1ns/1ps
`include "uart_mcr_defines.svh"
module uart_mcr_checker
	import uart_mcr_pkg::*;
#(
	parameter int NUM_IRQ_SRC = 4
)
(
	// Clock and reset
	input wire logic                   core_clk,
	input wire logic                   rst_b,
	// APB
	input wire logic                   psel,
	input wire logic                   penable,
	input wire logic                   pwrite,
	input wire logic [`MCR_ADDR_W-1:0] paddr,
	input wire logic [31:0]            pwdata,
	input wire logic [3:0]             pstrb,
	input wire logic                   pready,
	input wire logic [31:0]            prdata,
	// Serial, modem and interrupt
	input wire logic                   serialTxData,
	input wire logic                   rxToReceiver,
	input wire logic                   rxPin,
	input wire logic                   serialTxPin,
	input wire logic                   rtsPinN,
	input wire logic                   dtrPinN,
	input wire logic                   auxOnePinN,
	input wire logic                   auxTwoPinN,
	input wire modem_lines_t           modemToStatus,
	input wire logic [NUM_IRQ_SRC-1:0] irqSources,
	input wire logic                   portIrq
);
	// ----------------
	// Shadow state
	// ----------------
	logic [4:0] ctlReg, ctlD1, ctlD2;
	logic       cfgReg;
	logic [7:0] enReg;
	wire acc = psel && penable && pready;
	wire wrOk = acc && pwrite && pstrb[0];
	wire wrCtl = wrOk && paddr == 12'h000;
	wire irqHit = (ctlReg[4] ? cfgReg : ctlReg[3]) && |(irqSources & enReg[NUM_IRQ_SRC-1:0]);
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			ctlReg <= 5'h00;
			cfgReg <= 1'h0;
			enReg <= 8'h00;
		end else if (wrOk) begin
			if (paddr == 12'h000) ctlReg <= pwdata[4:0];
			if (paddr == 12'h004) cfgReg <= pwdata[0];
			if (paddr == 12'h008) enReg <= pwdata[7:0];
		end
	end
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			{ctlD1, ctlD2} <= 10'h000;
		end else begin
			{ctlD1, ctlD2} <= {ctlReg, ctlD1};
		end
	end
	// ----------------
	// Checks
	// ----------------
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	property p_rts; wrCtl |-> ##2 rtsPinN == !$past(pwdata[1], 2); endproperty
	a_rts: assert property (p_rts) else $error("rts pin wrong");
	property p_dtr; dtrPinN == !ctlD1[0]; endproperty
	a_dtr: assert property (p_dtr) else $error("dtr pin wrong");
	property p_aux1; auxOnePinN == !ctlD1[2]; endproperty
	a_aux1: assert property (p_aux1) else $error("aux one pin wrong");
	property p_aux2; auxTwoPinN == !ctlD1[3]; endproperty
	a_aux2: assert property (p_aux2) else $error("aux two pin wrong");
	property p_tx; ctlD1[4] |-> serialTxPin; endproperty
	a_tx: assert property (p_tx) else $error("tx pin not high in loop");
	property p_st;
		ctlD1[4] |-> modemToStatus == ~{ctlD1[3], ctlD1[2], ctlD1[0], ctlD1[1]};
	endproperty
	a_st: assert property (p_st) else $error("looped modem inputs wrong");
	property p_rxl; ctlD1[4] |-> rxToReceiver == $past(serialTxData); endproperty
	a_rxl: assert property (p_rxl) else $error("loop data not received");
	property p_rxn; !ctlD1[4] |-> rxToReceiver == $past(rxPin); endproperty
	a_rxn: assert property (p_rxn) else $error("pin data not received");
	property p_irq; !$past(wrOk) && !$past(wrOk, 2) |-> portIrq == $past(irqHit); endproperty
	a_irq: assert property (p_irq) else $error("interrupt gate wrong");
	property p_rd;
		acc && !pwrite && paddr == 12'h000 && !$past(wrOk) |-> prdata == {27'h7, ctlReg};
	endproperty
	a_rd: assert property (p_rd) else $error("control readback wrong");
	c_loopIrq: cover property (ctlD2[4] && portIrq);
	c_loopOn: cover property (wrCtl && pwdata[4]);
	c_normIrq: cover property (!ctlD2[4] && portIrq);
endmodule : uart_mcr_checker

// ===== tb/modem_far_end.sv
// Purpose: Behavioural external modem facing the port pins.
// Assumes: Pins are sampled on core_clk.
// Notes:   Receive data echoes transmit inverted, so looped data differs from outside data.
`timescale 1ns/1ps
module modem_far_end
	import uart_mcr_pkg::*;
(
	// Clock and reset
	input  wire logic   core_clk,
	input  wire logic   rst_b,
	// Port outputs, plus the line state from the bench
	input  wire logic   serialTxPin,
	input  wire logic   rtsPinN,
	input  wire logic   dtrPinN,
	input  wire logic [1:0] lineState,
	// Port inputs
	output logic         rxPin,
	output modem_lines_t modemPins
);
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rxPin <= 1'b1;
			modemPins <= 4'hF;
		end else begin
			rxPin <= !serialTxPin;
			modemPins <= {lineState, dtrPinN, rtsPinN};
		end
	end
endmodule : modem_far_end

// ===== tb/tb.sv
// Purpose: Self-checking bench for the modem control block.
// Assumes: Zero-wait APB slave, but the master waits for pready anyway.
// Notes:   Random control words with fixed corner cases first.
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fails++; \
	$display("unexpected at %0t: %h vs %h", $time, (a), (b)); end end
module tb;
	import uart_mcr_pkg::*;
	localparam int NUM_IRQ_SRC = 4;
	logic        core_clk, rst_b, psel, penable, pwrite, serialTxData, pslverr, pready;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, rnd, xs;
	logic [3:0]  pstrb, irqSources;
	logic [1:0]  lineState;
	logic [4:0]  ctl;
	logic [7:0]  en;
	logic        er, cfg, rxToReceiver, rxPin, serialTxPin, portIrq;
	logic        rtsPinN, dtrPinN, auxOnePinN, auxTwoPinN;
	modem_lines_t modemPins, modemToStatus;
	int          fails, comparisons, seed;
	uart_modem_control_loopback #(.NUM_IRQ_SRC(NUM_IRQ_SRC)) u_uart_modem_control_loopback (
		.core_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready,
		.prdata, .pslverr, .serialTxData, .rxToReceiver, .rxPin, .serialTxPin, .rtsPinN,
		.dtrPinN, .auxOnePinN, .auxTwoPinN, .modemPins, .modemToStatus, .irqSources, .portIrq);
	modem_far_end u_modem_far_end (.core_clk, .rst_b, .serialTxPin, .rtsPinN, .dtrPinN,
		.lineState, .rxPin, .modemPins);
	function automatic logic [3:0] exp_status(logic [4:0] c, modem_lines_t p);
		return c[4] ? ~{c[3], c[2], c[0], c[1]} : p;
	endfunction : exp_status
	function automatic logic exp_irq(logic [4:0] c, logic g, logic [7:0] e, logic [3:0] s);
		return (c[4] ? g : c[3]) && |(s & e[3:0]);
	endfunction : exp_irq
	task automatic apb(logic w, logic [11:0] a, logic [31:0] d, logic [3:0] s);
		@(posedge core_clk);
		{psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, d, s};
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		{psel, penable} <= 2'b00;
	endtask : apb
	task automatic print_verdict();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : print_verdict
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	initial begin
		repeat (20000) @(posedge core_clk);
		fails++;
		print_verdict();
	end
	initial begin
		{rst_b, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
		{serialTxData, irqSources, lineState} = '0;
		seed = 32'h57B3AC61;
		repeat (10) @(posedge core_clk);
		rst_b <= 1'b1;
		apb(0, 12'h000, 0, 4'hF);
		`CHK(rd, 32'h000000E0)
		`CHK({rtsPinN, dtrPinN, auxOnePinN, auxTwoPinN}, 4'hF)
		apb(0, 12'h010, 0, 4'hF);
		`CHK({er, rd}, {1'b1, 32'h0})
		for (int i = 0; i < 40; i++) begin
			rnd = $random(seed);
			ctl = (i == 0) ? 5'h1F : (i == 1) ? 5'h10 : rnd[4:0];
			cfg = 1'($random(seed));
			en = 8'($random(seed));
			apb(1, 12'h004, {31'h0, cfg}, 4'hF);
			apb(1, 12'h008, {24'h0, en}, 4'hF);
			apb(1, 12'h000, {rnd[31:5], ctl}, 4'hF);
			irqSources <= 4'($random(seed));
			serialTxData <= 1'($random(seed));
			lineState <= 2'($random(seed));
			repeat (5) @(posedge core_clk);
			`CHK({rtsPinN, dtrPinN, auxOnePinN, auxTwoPinN}, ~{ctl[1:0], ctl[2], ctl[3]})
			`CHK(serialTxPin, ctl[4] | serialTxData)
			`CHK(rxToReceiver, ctl[4] ? serialTxData : ~serialTxData)
			`CHK(modemToStatus, exp_status(ctl, modemPins))
			`CHK(portIrq, exp_irq(ctl, cfg, en, irqSources))
			apb(0, 12'h000, 0, 4'h0);
			`CHK(rd, {27'h7, ctl})
			apb(0, 12'h004, 0, 4'hF);
			`CHK({er, rd}, {1'b0, 31'h0, cfg})
			apb(0, 12'h008, 0, 4'hF);
			`CHK({er, rd}, {1'b0, 24'h0, en})
			xs = {26'h0, exp_irq(ctl, cfg, en, irqSources), ctl[4] | serialTxData,
				~exp_status(ctl, modemPins)};
			apb(0, 12'h00C, 0, 4'hF);
			`CHK({er, rd}, {1'b0, xs})
		end
		apb(1, 12'h000, 32'h0, 4'h0);
		apb(0, 12'h000, 0, 4'hF);
		`CHK(rd, {27'h7, ctl})
		print_verdict();
	end
endmodule : tb
bind uart_modem_control_loopback uart_mcr_checker #(.NUM_IRQ_SRC(NUM_IRQ_SRC)) u_uart_mcr_checker (
	.core_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata,
	.serialTxData, .rxToReceiver, .rxPin, .serialTxPin, .rtsPinN, .dtrPinN, .auxOnePinN,
	.auxTwoPinN, .modemToStatus, .irqSources, .portIrq);
